// file: pkg/adc_readout_pkg.sv
// package for the channel select and readout block
// assumes a 10 MHz host bus clock and one clock domain
`default_nettype none
package adc_readout_pkg;
  // =====================================================
  // widths
  localparam int RESULT_W = 12;
  localparam int BYTE_W   = 8;
  localparam int CHAN_W   = 4;
  // =====================================================
  // low byte layout
  localparam int LB_EOC_BIT   = 0;
  localparam int LB_BUSY_BIT  = 1;
  localparam int LB_START_BIT = 2;
  localparam int LB_ZERO_BIT  = 3;
  localparam int LB_DATA_LSB  = 4;
  // =====================================================
  // timing
  localparam int  CLK_PERIOD_NS   = 100;
  localparam int  SAR_PERIOD_NS   = 2500;   // approximation clock period
  localparam int  BUSY_MAX_NS     = 3800;   // busy low after start low
  localparam int  SAMPLE_NS       = 10000;  // sampling window
  localparam int  SAR_DIV_CYCLES  = SAR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int  BUSY_DLY_CYCLES = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int  SAMPLE_CYCLES   = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  DIV_W           = 6;
  localparam int  CNT_W           = 8;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
  // =====================================================
  // conversion sequencer states, gray along the path
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_WAIT   = 2'b11,
    ST_CONV   = 2'b10
  } conv_state_t;
endpackage
`default_nettype wire

// file: pkg/sar_if.sv
// interface between the sequencer and the approximation register
// assumes both ends on i_mclk
`timescale 1ns/1ps
`default_nettype none
interface sar_if;
  import adc_readout_pkg::*;
  logic                start;
  logic                step;
  logic                cmp_high;
  logic                done;
  logic [RESULT_W-1:0] result;
  modport ctrl (output start, output step, output cmp_high, input done, input result);
  modport sar  (input start, input step, input cmp_high, output done, output result);
endinterface
`default_nettype wire

// file: rtl/approx_reg.sv
// successive approximation register, one bit per step
// assumes start and step are one-cycle pulses on i_mclk
`timescale 1ns/1ps
`default_nettype none
module approx_reg
  import adc_readout_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  sar_if.sar        s
);
  logic [RESULT_W-1:0] trial_ff;
  logic [RESULT_W-1:0] mask_ff;
  logic                done_ff;
  logic [RESULT_W-1:0] kept;

  // =====================================================
  // keep the trial bit when comparator reads high
  assign kept     = s.cmp_high ? trial_ff : (trial_ff & ~mask_ff);
  assign s.result = trial_ff;
  assign s.done   = done_ff;

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      trial_ff <= '0;
      mask_ff  <= '0;
      done_ff  <= 1'b0;
    end
    else if (s.start)
    begin
      trial_ff <= {1'b1, {(RESULT_W-1){1'b0}}};
      mask_ff  <= {1'b1, {(RESULT_W-1){1'b0}}};
      done_ff  <= 1'b0;
    end
    else if (s.step && mask_ff != '0)
    begin
      trial_ff <= kept | (mask_ff >> 1);
      mask_ff  <= mask_ff >> 1;
      done_ff  <= (mask_ff == {{(RESULT_W-1){1'b0}}, 1'b1});
    end
    else
      done_ff <= 1'b0;
  end
endmodule
`default_nettype wire

// file: rtl/adc_channel_select_readout.sv
// channel select, conversion sequencing and byte readout of the analog input block
// assumes host bus strobes synchronous to i_mclk, comparator level on i_cmp_high
// Notes on behaviour
// - twelve-bit result, left-justified over two bytes
// - low byte: result bits 0-3 on lines 4-7
// - low byte: eoc line 0, busy 1, start 2
// - low byte bit 3 reads zero
// - high byte: result bits 4-11 on lines 0-7
// - every low-byte read carries live status
// - start flag low during sampling, high after
// - codes 0-7 select channels 0-7
// - codes 8-15 single-ended only
// - busy low within 3.8 us of start low
// - busy high only when result complete
// - eoc asserted at completion, cleared by high read
// - interrupt is inverse of eoc flag
// - channel write loads select, starts conversion
// - byte select low high byte, high low byte
// - bus reset clears divider and interrupt
// - divide bus clock to about 2.5 us
`timescale 1ns/1ps
`default_nettype none
module adc_channel_select_readout
  import adc_readout_pkg::*;
#(
  parameter int SAR_DIV = SAR_DIV_CYCLES,
  parameter int SAMPLE  = SAMPLE_CYCLES
)
(
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire logic              i_bus_reset,
  input  wire logic              i_select_n,
  input  wire logic              i_rd_n,
  input  wire logic              i_wr_n,
  input  wire logic              i_byte_select,
  input  wire logic [BYTE_W-1:0] i_host_data_lines,
  input  wire logic              i_cmp_high,
  output logic      [BYTE_W-1:0] o_host_data_lines,
  output logic                   o_host_data_oe,
  output logic      [CHAN_W-1:0] o_channel,
  output logic                   o_sample_hold,
  output logic                   o_done_irq
);
  sar_if s ();

  conv_state_t         state_ff, nxt_state;
  logic [CHAN_W-1:0]   chan_ff;
  logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
  logic [DIV_W-1:0]    div_ff;
  logic [RESULT_W-1:0] result_ff;
  logic                eoc_n_ff, busy_n_ff, start_n_ff;
  logic                wr_ff, rd_ff;
  logic [BYTE_W-1:0]   data_ff;
  logic                oe_ff;
  logic                sar_step_ff;

  logic              wr_now, rd_now, wr_end, rd_high, rd_low, div_wrap;
  logic              sample_end, conv_done, flag_clear;
  logic [BYTE_W-1:0] low_byte, high_byte, read_byte;

  // =====================================================
  // bus strobe decode; a write acts when its strobe ends
  assign wr_now     = !i_select_n && !i_wr_n;
  assign rd_now     = !i_select_n && !i_rd_n;
  assign wr_end     = wr_ff && !wr_now;
  assign rd_high    = rd_now && !rd_ff && !i_byte_select;
  assign rd_low     = rd_now && i_byte_select;
  assign div_wrap   = div_ff == DIV_W'(SAR_DIV - 1);
  assign sample_end = cnt_ff == CNT_W'(SAMPLE - 1);
  assign conv_done  = s.done && (state_ff == ST_CONV) && !wr_end;  // an abort discards a late finish
  assign flag_clear = i_bus_reset || rd_high;

  // =====================================================
  // byte layout, result left-justified over both bytes
  assign low_byte  = {result_ff[3:0], 1'b0, start_n_ff, busy_n_ff, eoc_n_ff};
  assign high_byte = result_ff[RESULT_W-1:4];
  assign read_byte = i_byte_select ? low_byte : high_byte;

  // =====================================================
  // approximation wiring; the comparator is sampled each step
  assign s.start    = (state_ff == ST_WAIT) && div_wrap;
  assign s.step     = sar_step_ff;
  assign s.cmp_high = i_cmp_high;

  approx_reg u_sar (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .s        (s)
  );

  // =====================================================
  // sequencer next state; a new write always restarts sampling
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (wr_end)
    begin
      nxt_state = ST_SAMPLE;
      nxt_cnt   = '0;
    end
    else
      unique case (state_ff)
        ST_IDLE:   nxt_cnt = '0;
        ST_SAMPLE:
        begin
          nxt_cnt = cnt_ff + 1'b1;
          if (sample_end)
            nxt_state = ST_WAIT;
        end
        ST_WAIT:   if (div_wrap) nxt_state = ST_CONV;
        ST_CONV:   if (s.done) nxt_state = ST_IDLE;
      endcase
  end

  // =====================================================
  // divider; bus reset clears it, writes realign it
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      div_ff <= '0;
    else if (i_bus_reset || wr_end || div_wrap)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  // =====================================================
  // state, channel and strobe history
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= '0;
      chan_ff     <= CHAN_RESET;
      wr_ff       <= 1'b0;
      rd_ff       <= 1'b0;
      sar_step_ff <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      wr_ff       <= wr_now;
      rd_ff       <= rd_now;
      sar_step_ff <= (state_ff == ST_CONV) && div_wrap && !wr_end;
      if (wr_now)
        chan_ff <= i_host_data_lines[CHAN_W-1:0];
    end
  end

  // =====================================================
  // status flags; completion wins over a same-cycle high read
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      start_n_ff <= 1'b1;
      busy_n_ff  <= 1'b1;
      eoc_n_ff   <= 1'b1;
      result_ff  <= '0;
    end
    else
    begin
      start_n_ff <= (nxt_state != ST_SAMPLE);
      // busy falls on the same edge as start, far inside the deadline
      busy_n_ff  <= (nxt_state == ST_IDLE);
      if (conv_done)
        result_ff <= s.result;
      if (conv_done)
        eoc_n_ff <= 1'b0;
      else if (flag_clear)
        eoc_n_ff <= 1'b1;
    end
  end

  // =====================================================
  // registered outputs; the bus drives only during a read
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      data_ff       <= '0;
      oe_ff         <= 1'b0;
      o_channel     <= CHAN_RESET;
      o_sample_hold <= 1'b0;
      o_done_irq    <= 1'b0;
    end
    else
    begin
      data_ff       <= read_byte;
      oe_ff         <= rd_now;
      o_channel     <= chan_ff;
      o_sample_hold <= (nxt_state == ST_SAMPLE);
      o_done_irq    <= conv_done ? 1'b1 : flag_clear ? 1'b0 : !eoc_n_ff;
    end
  end

  assign o_host_data_lines = data_ff;
  assign o_host_data_oe    = oe_ff;

  // =====================================================
  // checks
  chk_irq_tracks_eoc: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_done_irq == !eoc_n_ff) else $error("irq not inverse of eoc");
  chk_low_zero_bit: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_host_data_oe && $past(i_byte_select) |-> !o_host_data_lines[LB_ZERO_BIT])
    else $error("low byte bit 3 not zero");
  chk_high_read_clears: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    rd_high && !(s.done && state_ff == ST_CONV) |=> eoc_n_ff) else $error("high read kept eoc");
  chk_write_starts: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_end |=> !start_n_ff && !busy_n_ff) else $error("write did not start");
  chk_busy_deadline: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $fell(start_n_ff) |-> !busy_n_ff) else $error("busy late after start");
  chk_busy_done: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(busy_n_ff) |-> !eoc_n_ff && result_ff == $past(s.result)) else $error("busy rose early");
  chk_sample_high: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(start_n_ff) && state_ff == ST_WAIT |-> !busy_n_ff) else $error("sampling end wrong");
  chk_bus_reset: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_bus_reset && !(s.done && state_ff == ST_CONV) |=> !o_done_irq && div_ff == '0)
    else $error("bus reset ignored");
  cov_convert: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(eoc_n_ff));
  cov_restart: cover property (@(posedge i_mclk) disable iff (!i_resetn) wr_end && state_ff == ST_CONV);
  cov_poll: cover property (@(posedge i_mclk) disable iff (!i_resetn) rd_low && !eoc_n_ff);
endmodule
`default_nettype wire

// file: sim/host_model.sv
// host bus model: channel writes and byte reads on the select/strobe bus
// assumes the device samples strobes on rising i_mclk
`timescale 1ns/1ps
`default_nettype none
module host_model
  import adc_readout_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic [BYTE_W-1:0] i_rd_data,
  input  wire logic              i_rd_oe,
  output logic                   o_select_n,
  output logic                   o_rd_n,
  output logic                   o_wr_n,
  output logic                   o_byte_select,
  output logic      [BYTE_W-1:0] o_wr_data
);
  // ==========================================
  // idle bus; released data shows the inverse of its last value
  initial
  begin
    o_select_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_byte_select = 1'b1;
    o_wr_data = 8'h00;
  end
  // one write; the device acts when the strobe goes away
  task automatic wr(input logic [BYTE_W-1:0] b);
    @(posedge i_mclk);
    o_select_n <= 1'b0;
    o_wr_n <= 1'b0;
    o_wr_data <= b;
    @(posedge i_mclk);
    o_select_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_wr_data <= ~b;
  endtask
  // one read; byte select low for the high byte
  task automatic rd(input logic bs, output logic [BYTE_W-1:0] d, output logic oe);
    @(posedge i_mclk);
    o_select_n <= 1'b0;
    o_rd_n <= 1'b0;
    o_byte_select <= bs;
    @(posedge i_mclk);
    #1;
    d = i_rd_data;
    oe = i_rd_oe;
    @(posedge i_mclk);
    o_select_n <= 1'b1;
    o_rd_n <= 1'b1;
    o_byte_select <= ~bs;
  endtask
endmodule
`default_nettype wire

// file: sim/adc_channel_select_readout_bench.sv
// self-checking bench: every channel code, aborts and a bus reset
// assumes the host model drives the bus and a comparator target held per conversion
`timescale 1ns/1ps
`default_nettype none
module adc_channel_select_readout_bench;
  import adc_readout_pkg::*;
  logic        i_mclk;
  logic        i_resetn;
  logic        i_bus_reset;
  logic        i_cmp_high;
  logic        sel_n;
  logic        rd_n;
  logic        wr_n;
  logic        bsel;
  logic [7:0]  wdata;
  logic [7:0]  o_host_data_lines;
  logic        o_host_data_oe;
  logic [3:0]  o_channel;
  logic        o_sample_hold;
  logic        o_done_irq;
  int          n_mismatch;
  int          checked;
  logic [7:0]  d;
  logic        oe;
  logic [11:0] target;
  // ==========================================
  // short counts keep a conversion near forty cycles
  adc_channel_select_readout #(.SAR_DIV(2), .SAMPLE(8)) dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_bus_reset(i_bus_reset), .i_select_n(sel_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_byte_select(bsel),
    .i_host_data_lines(wdata), .i_cmp_high(i_cmp_high), .o_host_data_lines(o_host_data_lines),
    .o_host_data_oe(o_host_data_oe), .o_channel(o_channel), .o_sample_hold(o_sample_hold),
    .o_done_irq(o_done_irq));
  host_model host (.i_mclk(i_mclk), .i_rd_data(o_host_data_lines), .i_rd_oe(o_host_data_oe),
    .o_select_n(sel_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_byte_select(bsel), .o_wr_data(wdata));
  // ==========================================
  // clock and watchdog; a hang counts as a mismatch
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // comparator against the trial word: high while the input is at or above it,
  // so the approximation settles on target; one cycle late, fine for two-cycle steps
  always @(posedge i_mclk)
    i_cmp_high <= (target >= dut.s.result);
  initial
  begin
    #(30000 * 100);
    n_mismatch++;
    close_out();
  end
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  // expected low byte from result and the three status flags
  function automatic logic [7:0] lo_exp(input logic [11:0] r, input logic [2:0] st);
    return {r[3:0], 1'b0, st};
  endfunction
  // one conversion, optionally aborted first or ended by a bus reset
  task automatic convert(input logic [3:0] code, input logic abort, input logic brst);
    logic [11:0] r;
    r = 12'($urandom);
    target <= r;
    if (abort)
      host.wr({4'($urandom), ~code});
    host.wr({4'($urandom), code});
    host.rd(1'b1, d, oe);
    chk("status sampling", 12'h1, 12'(d[3:0]));
    chk("channel", 12'(code), 12'(o_channel));
    chk("sample hold", 12'h1, 12'(o_sample_hold));
    repeat (400)
    begin
      host.rd(1'b1, d, oe);
      if (d[0] === 1'b0)
        break;
    end
    chk("irq set", 12'h1, 12'(o_done_irq));
    chk("hold released", 12'h0, 12'(o_sample_hold));
    if (brst)
    begin
      i_bus_reset <= 1'b1;
      @(posedge i_mclk);
      i_bus_reset <= 1'b0;
      @(posedge i_mclk);
      #1;
      chk("irq bus reset", 12'h0, 12'(o_done_irq));
      host.rd(1'b1, d, oe);
      chk("eoc bus reset", 12'h1, 12'(d[0]));
      return;
    end
    repeat (2)
    begin
      host.rd(1'b1, d, oe);
      chk("low byte", 12'(lo_exp(r, 3'b110)), 12'(d));
    end
    host.rd(1'b0, d, oe);
    chk("high byte", 12'(r[11:4]), 12'(d));
    chk("oe", 12'h1, 12'(oe));
    chk("irq clear", 12'h0, 12'(o_done_irq));
    host.rd(1'b1, d, oe);
    chk("eoc clear", 12'(lo_exp(r, 3'b111)), 12'(d));
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    i_resetn = 1'b0;
    i_bus_reset = 1'b0;
    target = 12'h000;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'haa56cd1d));
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    host.rd(1'b1, d, oe);
    chk("idle status", 12'h7, 12'(d[3:0]));
    chk("idle irq", 12'h0, 12'(o_done_irq));
    $display("test reset done");
    for (int k = 0; k < 16; k++)
    begin
      convert(4'(k), (k == 5) || (k == 15) || ($urandom % 4 == 0), 1'b0);
      $display("test code %0d done", k);
    end
    convert(4'h3, 1'b0, 1'b1);
    convert(4'hf, 1'b1, 1'b0);
    $display("test bus reset done");
    close_out();
  end
endmodule
`default_nettype wire
